// [ras_pkg.sv]
`default_nettype none
package ras_pkg;
   localparam int unsigned DEPTH_DEF  = 31;
   localparam int unsigned PC_W_DEF   = 21;
   localparam int unsigned PTR_W      = 5;
   // register byte addresses on the bus
   localparam logic [7:0] OFF_INDEX   = 8'h00;
   localparam logic [7:0] OFF_TOP_LOW = 8'h04;
   localparam logic [7:0] OFF_TOP_HIGH= 8'h08;
   localparam logic [7:0] OFF_TOP_UPR = 8'h0c;
   localparam logic [7:0] OFF_CTRL    = 8'h10;
   // index register field positions
   localparam int unsigned FULL_BIT   = 7;
   localparam int unsigned UNF_BIT    = 6;
   // control register field positions
   localparam int unsigned FRE_BIT    = 0;
   localparam logic [4:0] PTR_RST     = 5'h00;
   localparam logic       FRE_RST     = 1'b1;
   localparam logic [1:0] HTRANS_NSEQ = 2'h2;

   typedef struct packed {
      logic        call;       // call or relative_call
      logic        irq_ack;    // acknowledged interrupt
      logic        ret;        // return, return_with_literal, return_from_interrupt
      logic [20:0] pc;         // current program counter
   } ras_core_req_type;

   typedef struct packed {
      logic        pc_load;    // one-cycle strobe: load pc_value
      logic [20:0] pc_value;
      logic        fault_reset;// one-cycle request for a device reset
   } ras_core_rsp_type;
endpackage
`default_nettype wire

// [ras_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R01] push pc on call or interrupt acknowledge
// [R02] pop entry into pc on returns
// [R03] pc latch registers left untouched
// [R04] 31 entries of 21 bits, 5-bit pointer
// [R05] every reset zeroes the pointer; por_n alone leaves it
// [R06] pointer zero has no entry
// [R07] push increments pointer then writes entry
// [R08] pop reads entry then decrements pointer
// [R09] stack storage private, no memory aliasing
// [R10] pointer readable and writable by software
// [R11] top registers mirror and write current entry
// [R12] software push/pop via top registers
// [R13] flags report full or beyond levels
// [R14] software masks interrupts during top edits
// [R15] index layout full7 unf6 ptr4:0 bit5 zero
// [R16] full on 31st push, reset or discard
// [R17] empty pop returns zero, sets underflow
// [R18] flags cleared only by software or poweron
// [R19] top registers read zero when pointer zero
module ras_top #(
   parameter int unsigned DEPTH = ras_pkg::DEPTH_DEF,
   parameter int unsigned PC_W  = ras_pkg::PC_W_DEF
) (
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      por_n,
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic      [31:0]               hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   input  wire ras_pkg::ras_core_req_type core_req,
   output ras_pkg::ras_core_rsp_type      core_rsp,
   output logic      [4:0]                stack_level_bits,
   output logic                           stack_full_flag,
   output logic                           stack_underflow_flag
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_DATA = 2'b10
   } ras_bus_state_type;

   // private storage, index 0 unused so entries sit at pointers 1..31
   logic [PC_W-1:0]   mem_q [1:DEPTH];                   // [R04] [R06] [R09]
   logic [PC_W-1:0]   mem_wdata;
   logic [4:0]        mem_waddr;
   logic              mem_we;

   logic [4:0]        ptr_q, ptr_d;
   logic              full_q, full_d;
   logic              unf_q, unf_d;
   logic              fre_q, fre_d;
   ras_bus_state_type bst_q, bst_d;
   logic [7:0]        aoff_q, aoff_d;
   logic              awr_q, awr_d;
   ras_pkg::ras_core_rsp_type rsp_q, rsp_d;

   logic [PC_W-1:0]   top_val;
   logic              push, pop;
   logic              sw_wr;
   logic [7:0]        wb;
   logic [31:0]       rd_mux;

   assign push  = core_req.call | core_req.irq_ack;       // [R01]
   assign pop   = core_req.ret;                          // [R02]
   assign sw_wr = (bst_q == ST_DATA) && awr_q;
   assign wb    = hwdata[7:0];

   // top of stack reads zero while nothing is selected
   always_comb begin
      top_val = '0;
      if (ptr_q != ras_pkg::PTR_RST) begin
         top_val = mem_q[ptr_q];                          // [R11] [R19]
      end
   end

   // bus phase tracking, always zero wait states
   always_comb begin
      bst_d  = ST_IDLE;
      aoff_d = aoff_q;
      awr_d  = 1'b0;
      if (hsel && hready && (htrans == ras_pkg::HTRANS_NSEQ)) begin
         bst_d  = ST_DATA;
         aoff_d = haddr[7:0];
         awr_d  = hwrite;
      end
      case (bst_q)
         ST_IDLE: ;
         ST_DATA: ;
         default: bst_d = ST_IDLE;
      endcase
   end

   // pointer, flags and core response; core actions outrank software writes, except a pointer write during an empty pop with fre_q clear
   always_comb begin
      ptr_d     = ptr_q;
      full_d    = full_q;
      unf_d     = unf_q;
      fre_d     = fre_q;
      rsp_d     = '0;
      mem_we    = 1'b0;
      mem_waddr = ptr_q;
      mem_wdata = top_val;
      if (sw_wr) begin
         case (aoff_q)
            ras_pkg::OFF_INDEX: begin
               ptr_d = wb[4:0];                           // [R10] [R12]
               // flags only clear from software, writing one keeps them
               if (!wb[ras_pkg::FULL_BIT]) full_d = 1'b0; // [R18]
               if (!wb[ras_pkg::UNF_BIT])  unf_d  = 1'b0; // [R18]
            end
            ras_pkg::OFF_TOP_LOW: begin
               mem_we    = (ptr_q != ras_pkg::PTR_RST);    // [R11]
               mem_wdata = {top_val[PC_W-1:8], wb};
            end
            ras_pkg::OFF_TOP_HIGH: begin
               mem_we    = (ptr_q != ras_pkg::PTR_RST);    // [R11]
               mem_wdata = {top_val[PC_W-1:16], wb, top_val[7:0]};
            end
            ras_pkg::OFF_TOP_UPR: begin
               mem_we    = (ptr_q != ras_pkg::PTR_RST);    // [R11]
               mem_wdata = {wb[PC_W-17:0], top_val[15:0]};
            end
            ras_pkg::OFF_CTRL: fre_d = wb[ras_pkg::FRE_BIT];
            default: ;
         endcase
      end
      // only pc is saved or loaded; the latch registers live elsewhere
      if (push) begin                                     // [R03]
         if (ptr_q < 5'(DEPTH)) begin
            ptr_d     = ptr_q + 5'h01;                    // [R07]
            mem_we    = 1'b1;
            mem_waddr = ptr_q + 5'h01;                    // [R07]
            mem_wdata = core_req.pc;                      // [R01]
            if (ptr_q == 5'(DEPTH - 1)) begin
               full_d = 1'b1;                             // [R13] [R16]
               if (fre_q) begin
                  rsp_d.fault_reset = 1'b1;               // [R16]
               end
            end
         end else begin
            // a discarded push also outranks a software pointer write
            ptr_d  = ptr_q;                               // [R16] pointer holds
            mem_we = 1'b0;                                // [R16] discarded
            full_d = 1'b1;                                // [R13]
         end
      end else if (pop) begin
         rsp_d.pc_load = 1'b1;                            // [R02]
         if (ptr_q == ras_pkg::PTR_RST) begin
            rsp_d.pc_value = '0;                          // [R17]
            unf_d          = 1'b1;                        // [R17]
            rsp_d.fault_reset = fre_q;                    // [R17]
         end else begin
            rsp_d.pc_value = top_val;                     // [R08] read first
            ptr_d          = ptr_q - 5'h01;               // [R08] then decrement
         end
      end
      // a stack fault reset zeroes the pointer at the same edge
      if (rsp_d.fault_reset) begin
         ptr_d = ras_pkg::PTR_RST;                        // [R16] [R17]
      end
   end

   // storage has no reset, it is only read behind a nonzero pointer
   always_ff @(posedge hclk) begin
      if (mem_we && (mem_waddr != ras_pkg::PTR_RST)) begin
         mem_q[mem_waddr] <= mem_wdata;                   // [R07] [R11]
      end
   end

   // hresetn zeroes the pointer; por_n alone does not
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ptr_q  <= ras_pkg::PTR_RST;                      // [R05]
         fre_q  <= ras_pkg::FRE_RST;
         bst_q  <= ST_IDLE;
         aoff_q <= 8'h00;
         awr_q  <= 1'b0;
         rsp_q  <= '0;
      end else begin
         ptr_q  <= ptr_d;
         fre_q  <= fre_d;
         bst_q  <= bst_d;
         aoff_q <= aoff_d;
         awr_q  <= awr_d;
         rsp_q  <= rsp_d;
      end
   end

   // sticky flags survive ordinary resets; only power-on or a software write of zero clears them
   always_ff @(posedge hclk or negedge por_n) begin
      if (!por_n) begin
         full_q <= 1'b0;                                  // [R18]
         unf_q  <= 1'b0;                                  // [R18]
      end else begin
         full_q <= full_d;
         unf_q  <= unf_d;
      end
   end

   // read mux; index bit 5 and upper bits read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (aoff_q)
         ras_pkg::OFF_INDEX: begin
            rd_mux[4:0]               = ptr_q;            // [R10] [R15]
            rd_mux[ras_pkg::FULL_BIT] = full_q;           // [R15]
            rd_mux[ras_pkg::UNF_BIT]  = unf_q;            // [R15]
         end
         ras_pkg::OFF_TOP_LOW:  rd_mux[7:0] = top_val[7:0];
         ras_pkg::OFF_TOP_HIGH: rd_mux[7:0] = top_val[15:8];
         ras_pkg::OFF_TOP_UPR:  rd_mux[PC_W-17:0] = top_val[PC_W-1:16];
         ras_pkg::OFF_CTRL:     rd_mux[ras_pkg::FRE_BIT] = fre_q;
         default: ;
      endcase
   end

   assign hrdata               = (bst_q == ST_DATA) ? rd_mux : 32'h0000_0000;
   assign hreadyout            = 1'b1;
   assign hresp                = 1'b0;
   assign core_rsp             = rsp_q;
   assign stack_level_bits     = ptr_q;
   assign stack_full_flag      = full_q;                  // [R13]
   assign stack_underflow_flag = unf_q;                   // [R13]
endmodule // ras_top
`default_nettype wire

// [ras_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ras_checker #(
   parameter int unsigned DEPTH = ras_pkg::DEPTH_DEF
) (
   input wire logic                      hclk,
   input wire logic                      hresetn,
   input wire logic                      hsel,
   input wire logic [1:0]                htrans,
   input wire logic                      hwrite,
   input wire logic                      hready,
   input wire ras_pkg::ras_core_req_type core_req,
   input wire ras_pkg::ras_core_rsp_type core_rsp,
   input wire logic [4:0]                stack_level_bits,
   input wire logic                      stack_full_flag,
   input wire logic                      stack_underflow_flag
);
   logic       psh;
   logic       pop;
   logic       wr;
   logic [4:0] top;
   // a push wins over a return, so a pop only counts without one
   assign psh = core_req.call | core_req.irq_ack;
   assign pop = core_req.ret & !psh;
   assign wr  = hsel & hready & hwrite & (htrans == ras_pkg::HTRANS_NSEQ);
   assign top = 5'(DEPTH);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   push_step_a: assert property (psh && stack_level_bits < top - 5'h01
      |=> stack_level_bits == $past(stack_level_bits) + 5'h01) else $error("push step wrong");
   pop_step_a: assert property (pop && stack_level_bits != 5'h00
      |=> core_rsp.pc_load && stack_level_bits == $past(stack_level_bits) - 5'h01)
      else $error("pop step wrong");
   empty_pop_a: assert property (pop && stack_level_bits == 5'h00 |=> core_rsp.pc_load
      && core_rsp.pc_value == 21'h0 && stack_underflow_flag && stack_level_bits == 5'h00)
      else $error("empty pop wrong");
   full_set_a: assert property (psh && stack_level_bits == top - 5'h01 |=> stack_full_flag
      && (stack_level_bits == top || (core_rsp.fault_reset && stack_level_bits == 5'h00)))
      else $error("full flag not set");
   full_keep_a: assert property (psh && stack_level_bits == top
      |=> stack_level_bits == top) else $error("push beyond full moved pointer");
   load_pulse_a: assert property (core_rsp.pc_load == $past(pop))
      else $error("pc load pulse wrong");
   level_max_a: assert property (psh && stack_level_bits < top
      |=> stack_level_bits != 5'h00 || core_rsp.fault_reset) else $error("push left pointer empty");
   // a flag may only fall at the edge that ends a write data phase
   flag_keep_a: assert property (!wr ##1 1'b1 |=> (stack_full_flag || !$past(stack_full_flag))
      && (stack_underflow_flag || !$past(stack_underflow_flag))) else $error("flag lost");
   cover property (psh && stack_level_bits == top - 5'h01);
   cover property (pop && stack_level_bits == 5'h00);
   cover property (core_rsp.fault_reset);
endmodule // ras_checker
bind ras_top ras_checker #(.DEPTH(DEPTH)) u_ras_checker (.hclk, .hresetn, .hsel, .htrans,
   .hwrite, .hready, .core_req, .core_rsp, .stack_level_bits, .stack_full_flag,
   .stack_underflow_flag);
`default_nettype wire

// [ras_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ras_core_model (
   input  wire logic                      hclk,
   output ras_pkg::ras_core_req_type      core_req,
   input  wire ras_pkg::ras_core_rsp_type core_rsp
);
   ras_pkg::ras_core_rsp_type rsp;
   initial core_req = '0;
   // one operation, offered for one taking edge; answer read mid next cycle
   task op(input logic [2:0] k, input logic [20:0] pc);
      @(posedge hclk);
      core_req <= {k, pc};
      @(posedge hclk);
      core_req <= '0;
      @(negedge hclk);
      rsp = core_rsp;
   endtask
endmodule // ras_core_model
`default_nettype wire

// [ras_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ras_top_tb;
   logic                      hclk = 1'b0, hresetn = 1'b0, por_n = 1'b0, hsel = 1'b0;
   logic                      hwrite = 1'b0, hreadyout, hresp, full, unf;
   logic [31:0]               haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0]                htrans = 2'h0;
   logic [4:0]                lvl;
   ras_pkg::ras_core_req_type core_req;
   ras_pkg::ras_core_rsp_type core_rsp;
   int                        error_cnt = 0, checked = 0, cyc = 0;
   always #25 hclk = ~hclk;
   ras_top u_ras_top (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .core_req, .core_rsp,
      .stack_level_bits(lvl), .stack_full_flag(full), .stack_underflow_flag(unf));
   ras_core_model u_ras_core_model (.hclk, .core_req, .core_rsp);
   task finish_test;
      if (error_cnt == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // single word transfer; each phase held until ready is sampled high
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= ras_pkg::HTRANS_NSEQ;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk("register", q, e);
      chk("response", {31'h0, hresp}, 32'h0);
   endtask
   task pop(input logic [20:0] e);
      u_ras_core_model.op(3'h1, 21'h0);
      chk("popped pc", {11'h0, u_ras_core_model.rsp.pc_value}, {11'h0, e});
   endtask
   task rst(input logic p);
      @(posedge hclk);
      hresetn <= 1'b0;
      por_n   <= p;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      por_n   <= 1'b1;
   endtask
   task t_reset;
      rd(ras_pkg::OFF_INDEX, 32'h0);
      rd(ras_pkg::OFF_CTRL, 32'h1);
      rd(8'h20, 32'h0);
      xfer(1'b1, ras_pkg::OFF_TOP_LOW, 32'h55);
      rd(ras_pkg::OFF_TOP_LOW, 32'h0);
   endtask
   task t_push_pop;
      u_ras_core_model.op(3'h4, 21'h1abcde);
      u_ras_core_model.op(3'h2, 21'h012345);
      rd(ras_pkg::OFF_INDEX, 32'h2);
      rd(ras_pkg::OFF_TOP_LOW, 32'h45);
      rd(ras_pkg::OFF_TOP_HIGH, 32'h23);
      rd(ras_pkg::OFF_TOP_UPR, 32'h01);
      pop(21'h012345);
      pop(21'h1abcde);
   endtask
   // the core stays idle while software edits the top entry
   task t_soft;
      xfer(1'b1, ras_pkg::OFF_INDEX, 32'h1);
      xfer(1'b1, ras_pkg::OFF_TOP_LOW, 32'h78);
      xfer(1'b1, ras_pkg::OFF_TOP_HIGH, 32'h56);
      xfer(1'b1, ras_pkg::OFF_TOP_UPR, 32'h14);
      rd(ras_pkg::OFF_INDEX, 32'h1);
      pop(21'h145678);
   endtask
   task t_under;
      pop(21'h0);
      rd(ras_pkg::OFF_INDEX, 32'h40);
      rst(1'b1);
      rd(ras_pkg::OFF_INDEX, 32'h40);
      xfer(1'b1, ras_pkg::OFF_INDEX, 32'h0);
      rd(ras_pkg::OFF_INDEX, 32'h0);
   endtask
   task t_full;
      xfer(1'b1, ras_pkg::OFF_CTRL, 32'h0);
      for (int i = 1; i <= 31; i++) u_ras_core_model.op(3'h4, 21'(i));
      rd(ras_pkg::OFF_INDEX, 32'h9f);
      chk("status pins", {24'h0, full, unf, 1'b0, lvl}, 32'h9f);
      u_ras_core_model.op(3'h4, 21'h7ffff);
      rd(ras_pkg::OFF_TOP_LOW, 32'h1f);
      xfer(1'b1, ras_pkg::OFF_CTRL, 32'h1);
      xfer(1'b1, ras_pkg::OFF_INDEX, 32'h1e);
      u_ras_core_model.op(3'h4, 21'h1);
      chk("fault reset", {31'h0, u_ras_core_model.rsp.fault_reset}, 32'h1);
      rd(ras_pkg::OFF_INDEX, 32'h80);
      rst(1'b0);
      rd(ras_pkg::OFF_INDEX, 32'h0);
   endtask
   // a hung handshake must still end the run
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         finish_test;
      end
   end
   initial begin
      rst(1'b0);
      t_reset;
      t_push_pop;
      t_soft;
      t_under;
      t_full;
      finish_test;
   end
endmodule // ras_top_tb
`default_nettype wire
